// ---- shared/ssp_cfg.svh ----
// Constants for the source and probe instrument and its debug hub
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_IR_W 2
`define SSP_IR_QUERY 2'h0
`define SSP_IR_SEL 2'h1
`define SSP_IR_DATA 2'h2
`define SSP_IR_BYPASS 2'h3
`define SSP_IR_CAPTURE 2'h1
`define SSP_WORD_W 32
`define SSP_SEL_W 8
`define SSP_SEL_LSB 24
`define SSP_WORD_MSB 31
`define SSP_FLD_W 12
`define SSP_MAX_INST 128
`define SSP_MAX_W 512
`define SSP_SYNC_DEPTH 2
`endif

// ---- shared/ssp_pkg.sv ----
// Types for the source and probe instrument
`include "ssp_cfg.svh"
`default_nettype none
package ssp_pkg;
  typedef enum logic [3:0] {
    TLR, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } ssp_tap_e;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } ssp_jtag_s;
  typedef struct packed {
    logic clk;
    logic ena;
  } ssp_src_s;
  typedef logic [`SSP_IR_W-1:0] ssp_ir_t;
  typedef logic [`SSP_SEL_W-1:0] ssp_sel_t;
  typedef logic [`SSP_FLD_W-1:0] ssp_fld_t;
  typedef logic [`SSP_WORD_W-1:0] ssp_word_t;
endpackage
`default_nettype wire

// ---- logic/ssp_top.sv ----
// JTAG source and probe instrument: debug hub with an array of instances
// How it works
// - each instance drives source outputs and samples probe inputs.
// - data moves by shifting a chain through the JTAG pins.
// - probes sampled in one cycle; source writes reach src_reg two cycles after update.
// - probe bus comes from user outputs and may be unused.
// - source bus feeds user inputs and may be unused.
// - with source clock option, sources update on the source clock.
// - source enable gates source clock updates when selected.
// - source width per instance is a parameter up to 512 bits.
// - up to 128 instances, each selected separately by the host.
// - each instance holds a shift and a hold register per bit.
// - optional sync option adds two registers on each source bit.
// - shared hub logic talks to JTAG, apart from instance registers.
// - hub is built in and routes traffic to every instance.
// - a query register reports instance count and widths.
`include "ssp_cfg.svh"
`default_nettype none
module ssp_top import ssp_pkg::*; #(
  parameter int NUM_INST = 1,
  parameter int PROBE_W = 8,
  parameter int SOURCE_W = 8,
  parameter bit USE_SRC_CLK = 1'b0,
  parameter bit USE_SRC_ENA = 1'b0,
  parameter bit USE_SYNC = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire ssp_jtag_s jtag_i,
  input wire ssp_src_s src_i,
  input wire logic [NUM_INST*(PROBE_W > 0 ? PROBE_W : 1)-1:0] probe_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [NUM_INST*(SOURCE_W > 0 ? SOURCE_W : 1)-1:0] source_o
);
  // A zero width keeps one dummy bit so the ports stay legal
  localparam int PE = (PROBE_W > 0) ? PROBE_W : 1;
  localparam int SE = (SOURCE_W > 0) ? SOURCE_W : 1;
  localparam int MW = (PE > SE) ? PE : SE;
  localparam ssp_word_t QWORD = {ssp_sel_t'(NUM_INST), ssp_fld_t'(SOURCE_W), ssp_fld_t'(PROBE_W)};

  if (NUM_INST < 1 || NUM_INST > `SSP_MAX_INST || PROBE_W < 0 || SOURCE_W < 0 ||
      PROBE_W > `SSP_MAX_W || SOURCE_W > `SSP_MAX_W || (USE_SRC_ENA && !USE_SRC_CLK)) begin : g_bad_cfg
    $error("ssp_top: unsupported parameter set");
  end

  function automatic ssp_tap_e tap_step(input ssp_tap_e s, input logic tms);
    unique case (s)
      TLR: tap_step = tms ? TLR : IDLE;
      IDLE: tap_step = tms ? SEL_DR : IDLE;
      SEL_DR: tap_step = tms ? SEL_IR : CAP_DR;
      CAP_DR: tap_step = tms ? EX1_DR : SH_DR;
      SH_DR: tap_step = tms ? EX1_DR : SH_DR;
      EX1_DR: tap_step = tms ? UPD_DR : PA_DR;
      PA_DR: tap_step = tms ? EX2_DR : PA_DR;
      EX2_DR: tap_step = tms ? UPD_DR : SH_DR;
      UPD_DR: tap_step = tms ? SEL_DR : IDLE;
      SEL_IR: tap_step = tms ? TLR : CAP_IR;
      CAP_IR: tap_step = tms ? EX1_IR : SH_IR;
      SH_IR: tap_step = tms ? EX1_IR : SH_IR;
      EX1_IR: tap_step = tms ? UPD_IR : PA_IR;
      PA_IR: tap_step = tms ? EX2_IR : PA_IR;
      EX2_IR: tap_step = tms ? UPD_IR : SH_IR;
      UPD_IR: tap_step = tms ? SEL_DR : IDLE;
    endcase
  endfunction

  // Pin synchronisers; JTAG pins are slow against ref_clk_i
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic tck_prev_reg;
  logic sclk_prev_reg;
  // Not reset: a pin standing high must not look like a fresh edge after reset
  always_ff @(posedge ref_clk_i) begin
    pin_s1_reg <= {jtag_i, src_i};
    pin_s2_reg <= pin_s1_reg;
    tck_prev_reg <= pin_s2_reg[4];
    sclk_prev_reg <= pin_s2_reg[1];
  end
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic sclk_rise;
  logic src_go;
  assign tck_rise = pin_s2_reg[4] & ~tck_prev_reg;
  assign tck_fall = ~pin_s2_reg[4] & tck_prev_reg;
  assign tms = pin_s2_reg[3];
  assign tdi = pin_s2_reg[2];
  assign sclk_rise = pin_s2_reg[1] & ~sclk_prev_reg;
  assign src_go = sclk_rise && (pin_s2_reg[0] || !USE_SRC_ENA);

  // Hub state and per-instance register pairs
  ssp_tap_e tap_reg, tap_next;
  ssp_ir_t ir_reg, ir_next, irsh_reg, irsh_next;
  ssp_word_t misc_reg, misc_next;
  ssp_sel_t sel_reg, sel_next;
  logic tdo_reg, tdo_next, oe_reg, oe_next;
  logic [MW-1:0] shift_reg [NUM_INST];
  logic [MW-1:0] shift_next [NUM_INST];
  logic [MW-1:0] hold_reg [NUM_INST];
  logic [MW-1:0] hold_next [NUM_INST];
  int sel_idx;
  logic sel_ok;
  logic [PE-1:0] probe_sel;
  logic [MW-1:0] shift_sel;
  assign sel_idx = int'(sel_reg);
  assign sel_ok = sel_idx < NUM_INST;
  assign probe_sel = sel_ok ? probe_i[sel_idx*PE +: PE] : '0;
  assign shift_sel = sel_ok ? shift_reg[sel_idx] : '0;

  always_comb begin
    tap_next = tap_reg;
    ir_next = ir_reg;
    irsh_next = irsh_reg;
    misc_next = misc_reg;
    sel_next = sel_reg;
    tdo_next = tdo_reg;
    oe_next = oe_reg;
    shift_next = shift_reg;
    hold_next = hold_reg;
    if (tck_rise) begin
      tap_next = tap_step(tap_reg, tms);
      unique case (tap_reg)
        TLR: begin
          ir_next = `SSP_IR_QUERY;
          sel_next = '0;
        end
        CAP_IR: irsh_next = `SSP_IR_CAPTURE;
        SH_IR: irsh_next = {tdi, irsh_reg[`SSP_IR_W-1:1]};
        UPD_IR: ir_next = irsh_reg;
        CAP_DR: begin
          unique case (ir_reg)
            `SSP_IR_QUERY: misc_next = QWORD;
            `SSP_IR_SEL: misc_next = {sel_reg, {`SSP_SEL_LSB{1'b0}}};
            `SSP_IR_BYPASS: misc_next = '0;
            `SSP_IR_DATA: if (sel_ok) shift_next[sel_idx] = MW'(probe_sel);
          endcase
        end
        SH_DR: begin
          misc_next = {tdi, misc_reg[`SSP_WORD_MSB:1]};
          if (ir_reg == `SSP_IR_DATA && sel_ok) shift_next[sel_idx] = {tdi, shift_sel[MW-1:1]};
        end
        UPD_DR: begin
          if (ir_reg == `SSP_IR_SEL) sel_next = misc_reg[`SSP_WORD_MSB:`SSP_SEL_LSB];
          if (ir_reg == `SSP_IR_DATA && sel_ok) hold_next[sel_idx] = shift_sel;
        end
        default: ;
      endcase
    end
    // TDO changes on the falling edge so the host samples it stable
    if (tck_fall) begin
      oe_next = (tap_reg == SH_DR) || (tap_reg == SH_IR);
      tdo_next = 1'b0;
      if (tap_reg == SH_IR) tdo_next = irsh_reg[0];
      if (tap_reg == SH_DR) begin
        unique case (ir_reg)
          `SSP_IR_QUERY: tdo_next = misc_reg[0];
          `SSP_IR_SEL: tdo_next = misc_reg[`SSP_SEL_LSB];
          `SSP_IR_BYPASS: tdo_next = misc_reg[`SSP_WORD_MSB];
          `SSP_IR_DATA: tdo_next = shift_sel[0];
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tap_reg <= TLR;
      ir_reg <= `SSP_IR_QUERY;
      irsh_reg <= '0;
      misc_reg <= '0;
      sel_reg <= '0;
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      shift_reg <= '{default: '0};
      hold_reg <= '{default: '0};
    end else begin
      tap_reg <= tap_next;
      ir_reg <= ir_next;
      irsh_reg <= irsh_next;
      misc_reg <= misc_next;
      sel_reg <= sel_next;
      tdo_reg <= tdo_next;
      oe_reg <= oe_next;
      shift_reg <= shift_next;
      hold_reg <= hold_next;
    end
  end
  assign tdo_o = tdo_reg;
  assign tdo_oe_o = oe_reg;

  // Source output path
  logic [NUM_INST*SE-1:0] hold_flat;
  logic [NUM_INST*SE-1:0] src_reg, src_next;
  logic [NUM_INST*SE-1:0] sy1_reg, sy1_next, sy2_reg, sy2_next;
  always_comb begin
    for (int i = 0; i < NUM_INST; i++) begin
      hold_flat[i*SE +: SE] = hold_reg[i][SE-1:0];
    end
    src_next = src_reg;
    if (!USE_SRC_CLK || src_go) src_next = hold_flat;
    sy1_next = src_reg;
    sy2_next = sy1_reg;
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      src_reg <= '0;
      sy1_reg <= '0;
      sy2_reg <= '0;
    end else begin
      src_reg <= src_next;
      sy1_reg <= sy1_next;
      sy2_reg <= sy2_next;
    end
  end
  // The extra pair trades two cycles of latency for metastability margin
  if (USE_SYNC) begin : g_sync
    assign source_o = sy2_reg;
  end else begin : g_nosync
    assign source_o = src_reg;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cap_data;
    tck_rise && tap_reg == CAP_DR && ir_reg == `SSP_IR_DATA && sel_ok;
  endsequence
  sequence s_upd_data;
    tck_rise && tap_reg == UPD_DR && ir_reg == `SSP_IR_DATA && sel_ok;
  endsequence

  chk_probe_sample: assert property (s_cap_data |=> shift_sel[PE-1:0] == $past(probe_sel))
    else $error("probe not captured in one cycle");
  chk_hold_update: assert property (s_upd_data |=> hold_reg[sel_idx] == $past(shift_sel))
    else $error("hold register missed update");
  chk_direct_write: assert property ((!USE_SRC_CLK) ##0 s_upd_data
    |=> ##1 src_reg[sel_idx*SE +: SE] == $past(shift_sel[SE-1:0], 2))
    else $error("source not written after update");
  chk_src_gate: assert property (USE_SRC_CLK && !src_go |=> $stable(src_reg))
    else $error("source changed without enabled source clock");
  chk_src_clock: assert property (USE_SRC_CLK && src_go |=> src_reg == $past(hold_flat))
    else $error("source clock edge did not load sources");
  chk_sync_pair: assert property (USE_SYNC |-> ##2 source_o == $past(src_reg, 2))
    else $error("sync pair latency wrong");
  chk_query_word: assert property (tck_rise && tap_reg == CAP_DR && ir_reg == `SSP_IR_QUERY
    |=> misc_reg == QWORD)
    else $error("query word wrong");
  chk_sel_load: assert property (tck_rise && tap_reg == UPD_DR && ir_reg == `SSP_IR_SEL
    |=> sel_reg == $past(misc_reg[`SSP_WORD_MSB:`SSP_SEL_LSB]))
    else $error("instance select not loaded");
  chk_tdo_enable: assert property (tck_fall && tap_reg == IDLE |=> !tdo_oe_o [*1] ##0 tdo_o == 1'b0)
    else $error("tdo driven outside shift");
  chk_ir_reset: assert property (tck_rise && tap_reg == TLR |=> ir_reg == `SSP_IR_QUERY && sel_reg == '0)
    else $error("hub not reset in test logic reset");
endmodule
`default_nettype wire

// ---- test/ssp_jtag_host.sv ----
// JTAG host model that walks the TAP and shifts instruction and data frames
`default_nettype none
// Reads tdo from one device only; other devices may share its pins but are not read
module ssp_jtag_host import ssp_pkg::*; (
  input wire logic clk_i,
  input wire logic tdo_i,
  output var ssp_jtag_s jtag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  initial jtag_o = '0;
  // tck stands still between frames; tdo is taken just before the rising edge
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk_i);
    jtag_o <= '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (8) @(posedge clk_i);
    tdo = tdo_i;
    jtag_o.tck <= 1'b1;
    repeat (7) @(posedge clk_i);
  endtask
  task automatic reset_tap();
    logic t;
    repeat (5) tick(1'b1, ~last, t);
    tick(1'b0, ~last, t);
  endtask
  // Idle to shift, n bits LSB first, update, back to idle; tdi idles inverted
  task automatic frame(input bit ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, ~last, t);
    if (ir) begin
      tick(1'b1, ~last, t);
    end
    tick(1'b0, ~last, t);
    tick(1'b0, ~last, t);
    for (int k = 0; k < n; k++) begin
      tick(k == n - 1, din[k], t);
      last = din[k];
      dout[k] = t;
    end
    tick(1'b1, ~last, t);
    tick(1'b0, ~last, t);
  endtask
endmodule
`default_nettype wire

// ---- test/tb_ssp_top.sv ----
// Self-checking bench for the source and probe instrument
`include "ssp_cfg.svh"
`default_nettype none
module tb_ssp_top import ssp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NI = 2;
  localparam int W = 8;
  typedef logic [NI*W-1:0] ssp_bus_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  ssp_jtag_s jtag;
  ssp_bus_t probe = '0;
  ssp_src_s src = '0;
  ssp_bus_t src_v[2];
  logic tdo_v[2];
  logic oe_v[2];
  logic tdo;
  int exp_clk[NI];
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int exp_src[NI];
  int prev;
  logic [31:0] rd;
  always #5 ref_clk_i = ~ref_clk_i;
  // Copy 0 writes sources directly; copy 1 uses source clock, enable and sync pair
  for (genvar g = 0; g < 2; g++) begin : g_dut
    ssp_top #(.NUM_INST(NI), .PROBE_W(W), .SOURCE_W(W), .USE_SRC_CLK(g == 1), .USE_SRC_ENA(g == 1),
      .USE_SYNC(g == 1)) i_ssp_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .jtag_i(jtag), .src_i(src),
      .probe_i(probe), .tdo_o(tdo_v[g]), .tdo_oe_o(oe_v[g]), .source_o(src_v[g]));
  end
  assign tdo = tdo_v[0];
  ssp_jtag_host i_ssp_jtag_host (.clk_i(ref_clk_i), .tdo_i(tdo), .jtag_o(jtag));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run is 34 frames, some 6300 cycles in all
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic ir(input logic [1:0] code);
    i_ssp_jtag_host.frame(1'b1, 32'(code), `SSP_IR_W, rd);
    chk(32'(rd[1:0]), 32'(`SSP_IR_CAPTURE));
  endtask
  task automatic model_chk();
    for (int j = 0; j < NI; j++) begin
      chk(32'(src_v[0][j*W +: W]), 32'(exp_src[j]));
      chk(32'(src_v[1][j*W +: W]), 32'(exp_clk[j]));
    end
    chk(32'({oe_v[0], tdo_v[0]}), 32'h0000_0000);
    chk(32'({oe_v[1], tdo_v[1]}), 32'h0000_0000);
  endtask
  // One source clock pulse; the clocked copy loads only when enabled
  task automatic src_pulse(input bit e);
    @(posedge ref_clk_i);
    src <= '{clk: 1'b1, ena: e};
    repeat (8) @(posedge ref_clk_i);
    src <= '{clk: 1'b0, ena: 1'b0};
    repeat (8) @(posedge ref_clk_i);
    if (e) begin
      exp_clk = exp_src;
    end
  endtask
  initial begin
    logic [W-1:0] v;
    int s;
    bit e;
    void'($urandom(42));
    exp_src = '{default: 0};
    exp_clk = '{default: 0};
    prev = 0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    model_chk();
    i_ssp_jtag_host.reset_tap();
    ir(`SSP_IR_QUERY);
    i_ssp_jtag_host.frame(1'b0, 32'h0000_0000, `SSP_WORD_W, rd);
    chk(rd, {8'(NI), 12'(W), 12'(W)});
    ir(`SSP_IR_BYPASS);
    i_ssp_jtag_host.frame(1'b0, 32'h0000_0001, 1, rd);
    chk(rd, 32'h0000_0000);
    // Index NI is out of range: capture reads zero and no source moves
    for (int i = 0; i < 7; i++) begin
      s = i % (NI + 1);
      v = W'($urandom);
      probe <= ssp_bus_t'($urandom);
      ir(`SSP_IR_SEL);
      i_ssp_jtag_host.frame(1'b0, 32'(s), `SSP_SEL_W, rd);
      chk(rd, 32'(prev));
      prev = s;
      ir(`SSP_IR_DATA);
      i_ssp_jtag_host.frame(1'b0, 32'(v), W, rd);
      chk(rd, (s < NI) ? 32'(probe[s*W +: W]) : 32'h0000_0000);
      if (s < NI) begin
        exp_src[s] = int'(v);
      end
      model_chk();
      e = 1'($urandom);
      src_pulse(e);
      model_chk();
    end
    // Second reset in mid-run clears sources and the selection
    rst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    exp_src = '{default: 0};
    exp_clk = '{default: 0};
    model_chk();
    i_ssp_jtag_host.reset_tap();
    ir(`SSP_IR_SEL);
    i_ssp_jtag_host.frame(1'b0, 32'h0000_0001, `SSP_SEL_W, rd);
    chk(rd, 32'h0000_0000);
    end_of_test();
  end
endmodule
`default_nettype wire
